/* src/rpis_swizzle.sv */
`timescale 1ns/1ns
`include "rpis_defs.svh"
module rpis_swizzle (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic [3:0] P0_DOWN_INT,
   input  wire logic [3:0] P1_DOWN_INT,
   input  wire logic       P0_OWN_INT,
   input  wire logic       P1_OWN_INT,
   input  wire logic [1:0] OWN_LINE_SEL,
   output logic      [3:0] UP_INT,
   output logic      [4:0] DEVICE_NUM,
   output logic      [1:0] P0_FUNC_NUM,
   output logic      [1:0] P1_FUNC_NUM
);
   // rotate a line vector upward by rot positions; constant rot only
   function automatic rpis_pkg::rpis_lines_type rot_lines(input rpis_pkg::rpis_lines_type v,
                                                           input logic [1:0] rot);
      rpis_pkg::rpis_lines_type r;
      r = v;
      for (int i = 0; i < 4; i++) begin
         r[(i + int'(rot)) % 4] = v[i];
      end
      return r;
   endfunction : rot_lines

   function automatic rpis_pkg::rpis_lines_type one_hot(input logic [1:0] sel);
      rpis_pkg::rpis_lines_type r;
      r = 4'h0;
      r[sel] = 1'b1;
      return r;
   endfunction : one_hot

   // pin inputs pass two flops; stage one is read only by stage two
   logic [3:0] p0_meta;
   logic [3:0] p0_sync;
   logic [3:0] p1_meta;
   logic [3:0] p1_sync;
   logic [1:0] own_meta;
   logic [1:0] own_sync;
   logic [1:0] sel_meta;
   logic [1:0] sel_sync;

   always_ff @(posedge CLK) begin
      if (RST) begin
         p0_meta  <= 4'h0;
         p0_sync  <= 4'h0;
         p1_meta  <= 4'h0;
         p1_sync  <= 4'h0;
         own_meta <= 2'h0;
         own_sync <= 2'h0;
         sel_meta <= `RPIS_OWN_SEL_RST;
         sel_sync <= `RPIS_OWN_SEL_RST;
      end else begin
         p0_meta  <= P0_DOWN_INT;
         p0_sync  <= p0_meta;
         p1_meta  <= P1_DOWN_INT;
         p1_sync  <= p1_meta;
         own_meta <= {P1_OWN_INT, P0_OWN_INT};
         own_sync <= own_meta;
         sel_meta <= OWN_LINE_SEL;
         sel_sync <= sel_meta;
      end
   end

   // rotations are constants, no register can reach them
   wire [3:0] p0_mapped = rot_lines(p0_sync, `RPIS_PORT0_ROT);
   wire [3:0] p1_mapped = rot_lines(p1_sync, `RPIS_PORT1_ROT);
   wire [3:0] own_lines = (|own_sync) ? one_hot(sel_sync) : 4'h0;
   // wired-or sharing: line drops only when all sources have dropped
   wire [3:0] next_up   = p0_mapped | p1_mapped | own_lines;

   always_ff @(posedge CLK) begin
      if (RST) begin
         UP_INT <= 4'h0;
      end else begin
         UP_INT <= next_up;
      end
   end

   // identity of the two bridge functions
   assign DEVICE_NUM  = `RPIS_DEVICE_NUM;
   assign P0_FUNC_NUM = 2'h0;
   assign P1_FUNC_NUM = 2'h1;

   sequence s_p1_a;
      p1_sync[0] && !p0_sync[1] && !(|own_sync);
   endsequence

   a_port0_ident: assert property (@(posedge CLK) disable iff (RST)
      (p0_sync[2] |=> UP_INT[2]))
      else $error("port 0 line C not forwarded as C");
   a_port1_rotate: assert property (@(posedge CLK) disable iff (RST)
      (s_p1_a |=> UP_INT[1]))
      else $error("port 1 line A not forwarded as B");
   a_port1_wrap: assert property (@(posedge CLK) disable iff (RST)
      (p1_sync[3] |=> UP_INT[0]))
      else $error("port 1 line D not forwarded as A");
   a_relay_any: assert property (@(posedge CLK) disable iff (RST)
      ((|p0_sync) |=> (|UP_INT)))
      else $error("downstream assertion not relayed");
   a_no_spurious: assert property (@(posedge CLK) disable iff (RST)
      (!(|p0_sync) && !(|p1_sync) && !(|own_sync) |=> UP_INT == 4'h0))
      else $error("upstream line held with no source");
   a_shared_hold: assert property (@(posedge CLK) disable iff (RST)
      (p0_sync[1] && $fell(p1_sync[0]) |=> UP_INT[1]))
      else $error("shared line dropped while a source remains");
   a_own_route: assert property (@(posedge CLK) disable iff (RST)
      ((|own_sync) |=> UP_INT[$past(sel_sync)]))
      else $error("own interrupt not on selected line");
   a_fixed_id: assert property (@(posedge CLK) disable iff (RST)
      (DEVICE_NUM == 5'h17 && P1_FUNC_NUM == 2'h1))
      else $error("bridge identity wrong");

   // expected line of every source, taken from the mapping table rather than the datapath
   function automatic logic line_has_src(input rpis_pkg::rpis_lines_type p0,
                                         input rpis_pkg::rpis_lines_type p1,
                                         input logic [1:0]               own,
                                         input logic [1:0]               sel,
                                         input int                       j);
      logic hit;
      hit = p0[j] | p1[(j + 3) % 4];
      if ((|own) && (int'(sel) == j)) begin
         hit = 1'b1;
      end
      return hit;
   endfunction : line_has_src

   // named steps of the single-source checks
   sequence s_own_p1_only;
      own_sync[1] && !own_sync[0];
   endsequence

   sequence s_p0_single;
      $onehot(p0_sync) && !(|p1_sync) && !(|own_sync);
   endsequence

   sequence s_p1_single;
      $onehot(p1_sync) && !(|p0_sync) && !(|own_sync);
   endsequence

   sequence s_own_alone;
      (|own_sync) && !(|p0_sync) && !(|p1_sync);
   endsequence

   a_port0_exact: assert property (@(posedge CLK) disable iff (RST)
      (s_p0_single |=> UP_INT == $past(p0_sync)))
      else $error("port 0 single line not forwarded unchanged");

   a_port1_exact: assert property (@(posedge CLK) disable iff (RST)
      (s_p1_single |=> UP_INT == {$past(p1_sync[2:0]), $past(p1_sync[3])}))
      else $error("port 1 single line not rotated by one");

   a_own_port1: assert property (@(posedge CLK) disable iff (RST)
      (s_own_p1_only |=> UP_INT[$past(sel_sync)]))
      else $error("port 1 own interrupt not on selected line");

   a_own_both: assert property (@(posedge CLK) disable iff (RST)
      ((own_sync == 2'h3) |=> UP_INT[$past(sel_sync)]))
      else $error("shared own interrupts not on selected line");

   a_own_exact: assert property (@(posedge CLK) disable iff (RST)
      (s_own_alone |=> $onehot(UP_INT)))
      else $error("own interrupt drove more than one line");

   // clear at the edge after reset, not three edges later when the syncs drain
   a_reset_clear: assert property (@(posedge CLK)
      (RST |=> UP_INT == 4'h0))
      else $error("upstream lines not cleared by reset");

   a_sync_chain: assert property (@(posedge CLK) disable iff (RST)
      (!$past(RST) |-> (p0_sync == $past(p0_meta)) && (p1_sync == $past(p1_meta))))
      else $error("downstream synchroniser skipped a stage");

   a_own_chain: assert property (@(posedge CLK) disable iff (RST)
      (!$past(RST) |-> own_sync == $past(own_meta)))
      else $error("own interrupt synchroniser skipped a stage");

   a_sel_chain: assert property (@(posedge CLK) disable iff (RST)
      (!$past(RST) |-> sel_sync == $past(sel_meta)))
      else $error("line selection synchroniser skipped a stage");

   a_func_port0: assert property (@(posedge CLK) disable iff (RST)
      (P0_FUNC_NUM == 2'h0))
      else $error("port 0 function number wrong");

   // one block of checks per upstream line
   genvar j;
   generate
      for (j = 0; j < 4; j++) begin : g_line_chk
         sequence s_src_on;
            line_has_src(p0_sync, p1_sync, own_sync, sel_sync, j);
         endsequence

         sequence s_src_off;
            !line_has_src(p0_sync, p1_sync, own_sync, sel_sync, j);
         endsequence

         a_line_set: assert property (@(posedge CLK) disable iff (RST)
            (s_src_on |=> UP_INT[j]))
            else $error("upstream line missing while a source is high");

         a_line_clear: assert property (@(posedge CLK) disable iff (RST)
            (s_src_off |=> !UP_INT[j]))
            else $error("upstream line high with no source");

         a_port0_line: assert property (@(posedge CLK) disable iff (RST)
            (p0_sync[j] |=> UP_INT[j]))
            else $error("port 0 line not forwarded unchanged");

         a_port1_line: assert property (@(posedge CLK) disable iff (RST)
            (p1_sync[j] |=> UP_INT[(j + 1) % 4]))
            else $error("port 1 line not rotated by one");

         a_own_line: assert property (@(posedge CLK) disable iff (RST)
            ((|own_sync) && (sel_sync == 2'(j)) |=> UP_INT[j]))
            else $error("own interrupt missing on selected line");

         // a line may only drop once every source on it has gone
         a_share_line: assert property (@(posedge CLK) disable iff (RST)
            (p0_sync[j] && $fell(p1_sync[(j + 3) % 4]) |=> UP_INT[j]))
            else $error("shared line dropped while port 0 still drives it");
      end
   endgenerate
endmodule : rpis_swizzle

/* src/rpis_defs.svh */
// Operation
// - two root ports, functions 0 and 1 of device 23, forward secondary INTx upstream
// - every downstream INTx assertion is relayed upstream after per-port remapping
// - port 0 forwards lines unchanged, A to A through D to D
// - port 1 rotates lines by one: A to B, B to C, C to D, D to A
// - remapping is fixed in hardware with no software control
// - port-own interrupts bypass remapping and use the agent routing selection
`ifndef RPIS_DEFS_SVH
`define RPIS_DEFS_SVH
`define RPIS_NUM_PORTS   2
`define RPIS_NUM_LINES   4
`define RPIS_DEVICE_NUM  5'h17
`define RPIS_PORT0_ROT   2'h0
`define RPIS_PORT1_ROT   2'h1
`define RPIS_OWN_SEL_RST 2'h0
`define RPIS_LATENCY     3
`endif

/* src/rpis_pkg.sv */
package rpis_pkg;
   typedef logic [3:0] rpis_lines_type;
   typedef enum logic [1:0] {
      RPIS_INTA = 2'h0,
      RPIS_INTB = 2'h1,
      RPIS_INTC = 2'h2,
      RPIS_INTD = 2'h3
   } rpis_line_type;
endpackage : rpis_pkg

/* dv/rpis_ep_model.sv */
`timescale 1ns/1ns
// downstream endpoints of both ports; levels change only on clock edges
module rpis_ep_model (
   input  wire logic       clk,
   input  wire logic [7:0] req,
   output logic      [7:0] line
);
   always_ff @(posedge clk) begin
      line <= req;
   end
endmodule : rpis_ep_model

/* dv/tb_rpis_swizzle.sv */
`timescale 1ns/1ns
`include "rpis_defs.svh"
module tb_rpis_swizzle;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] req = 8'h00;
   logic [7:0] line;
   logic       o0  = 1'b0;
   logic       o1  = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [3:0] up;
   logic [4:0] dn;
   logic [1:0] f0, f1;
   int         fail_count = 0;
   int         num_checks = 0;
   initial begin
      forever #5 clk = ~clk;
   end
   rpis_ep_model rpis_ep_model_inst (.clk(clk), .req(req), .line(line));
   rpis_swizzle rpis_swizzle_inst (.CLK(clk), .RST(rst), .P0_DOWN_INT(line[3:0]),
      .P1_DOWN_INT(line[7:4]), .P0_OWN_INT(o0), .P1_OWN_INT(o1), .OWN_LINE_SEL(sel),
      .UP_INT(up), .DEVICE_NUM(dn), .P0_FUNC_NUM(f0), .P1_FUNC_NUM(f1));
   task chk(string n, logic [4:0] e, logic [4:0] s);
      num_checks++;
      if (e !== s) begin
         fail_count++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task chk_n(string n, int e, int s);
      num_checks++;
      if (e != s) begin
         fail_count++;
         $display("ERROR %s exp %0d got %0d", n, e, s);
      end
   endtask : chk_n
   // read on the falling edge, clear of the edge that launches the output;
   // the endpoint model adds one edge in front of the design's own latency
   task wt(logic [3:0] e, int lat = `RPIS_LATENCY + 2);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (up !== e && k < 16);
      chk("up_int", {1'b0, e}, {1'b0, up});
      chk_n("latency", lat, k);
      if (up !== e) begin
         results();
      end
   endtask : wt
   task put(logic [7:0] r, logic a, logic b, logic [1:0] s);
      @(posedge clk);
      req <= r;
      o0  <= a;
      o1  <= b;
      sel <= s;
   endtask : put
   task t_ids;
      chk("device", 5'h17, dn);
      chk("func0", 5'h00, {3'h0, f0});
      chk("func1", 5'h01, {3'h0, f1});
   endtask : t_ids
   task t_map;
      for (int i = 0; i < 8; i++) begin
         put(8'h01 << i, 1'b0, 1'b0, 2'h0);
         wt(4'h1 << (i < 4 ? i : (i + 1) % 4));
         put(8'h00, 1'b0, 1'b0, 2'h0);
         wt(4'h0);
      end
   endtask : t_map
   task t_own;
      for (int i = 0; i < 8; i++) begin
         put(8'h00, i < 4, i >= 4, 2'(i));
         wt(4'h1 << (i % 4), `RPIS_LATENCY + 1);
         put(8'h00, 1'b0, 1'b0, 2'(i));
         wt(4'h0, `RPIS_LATENCY + 1);
      end
   endtask : t_own
   task t_share;
      put(8'h81, 1'b0, 1'b0, 2'h0);
      wt(4'h1);
      put(8'h01, 1'b0, 1'b0, 2'h0);
      repeat (6) @(posedge clk);
      chk("shared", 5'h01, {1'b0, up});
      put(8'h00, 1'b0, 1'b0, 2'h0);
      wt(4'h0);
   endtask : t_share
   task t_rst;
      put(8'h10, 1'b0, 1'b0, 2'h0);
      wt(4'h2);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk("reset", 5'h00, {1'b0, up});
      @(posedge clk);
      rst <= 1'b0;
      wt(4'h2, `RPIS_LATENCY + 1);
      put(8'h00, 1'b0, 1'b0, 2'h0);
      wt(4'h0);
   endtask : t_rst
   task results;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_ids();
      t_map();
      t_own();
      t_share();
      t_rst();
      results();
   end
endmodule : tb_rpis_swizzle
